// file: rtl/smb_pkg.sv
// constants and types for the smbus target with output gating
// assumes one 100 MHz clock and a synchronous active-high reset
//
// Contract
// [R1] ack write address matching own address
// [R2] ack offset byte, load register pointer
// [R3] ack byte count in a write
// [R4] store data bytes N..N+X-1, ack each
// [R5] host ends write with stop
// [R6] host reads via offset write, repeated start
// [R7] first read byte is the count X
// [R8] then return registers from N upward
// [R9] host acks every read byte but last
// [R10] host ends read with nack then stop
// [R11] bus address from two three-level straps
// [R12] byte 0 bits 5..0 gate fixed pairs
// [R13] host writes zero to reserved bits
// [R14] byte 1 bits 6..1 gate muxed pairs
// [R15] byte 2 bit 2 gates low-frequency pair
// [R16] override bit lets bit 7 choose frequency
// [R17] no override means 100 MHz; reserved reads zero
// [R18] ignore foreign addresses, keep bus released
package smb_pkg;
   // one data byte on the bus
   typedef logic [7:0] smb_byte_t;
   // three-level strap code: 00 low, 01 mid, 10 high
   typedef logic [1:0] smb_strap_t;

   // number of implemented register bytes
   localparam int SMB_NUM_REGS = 3;
   localparam smb_byte_t SMB_REG_FIXED = 8'h00;
   localparam smb_byte_t SMB_REG_MUXED = 8'h01;
   localparam smb_byte_t SMB_REG_SEL = 8'h02;

   // writable bits per byte; others read as zero
   localparam smb_byte_t SMB_MASK_FIXED = 8'h3f;
   localparam smb_byte_t SMB_MASK_MUXED = 8'h7e;
   localparam smb_byte_t SMB_MASK_SEL = 8'hc4;
   // reset values per byte
   localparam smb_byte_t SMB_RST_FIXED = 8'h3f;
   localparam smb_byte_t SMB_RST_MUXED = 8'h7e;
   localparam smb_byte_t SMB_RST_SEL = 8'h04;

   // field positions
   localparam int SMB_FIXED_LSB = 0;
   localparam int SMB_MUXED_LSB = 1;
   localparam int SMB_LOWF_BIT = 2;
   localparam int SMB_OVR_BIT = 6;
   localparam int SMB_CHOICE_BIT = 7;

   // count returned ahead of read data until a write sets one
   localparam smb_byte_t SMB_RD_COUNT_RST = 8'h03;

   // addresses, index = high_level * 3 + low_level
   localparam smb_byte_t [8:0] SMB_ADDR_TAB = {
      8'hbe, 8'hbc, 8'hba, 8'hb6, 8'hb4, 8'hb2, 8'hd6, 8'hd4, 8'hd2};
   localparam smb_strap_t SMB_STRAP_HIGH = 2'h2;
   localparam logic [3:0] SMB_STRAP_MULT = 4'h3;

   // bit counter marks
   localparam logic [3:0] SMB_BITS_BYTE = 4'h8;
   localparam logic [3:0] SMB_BIT_LAST = 4'h7;

   // protocol states
   typedef enum logic [2:0] {
      SMB_ST_IDLE, SMB_ST_RX, SMB_ST_ACK, SMB_ST_TX, SMB_ST_MACK, SMB_ST_SKIP
   } smb_state_t;
   // what the byte being received means
   typedef enum logic [1:0] {
      SMB_K_ADDR, SMB_K_OFF, SMB_K_CNT, SMB_K_DATA
   } smb_kind_t;
endpackage

// file: rtl/smb_line_if.sv
// bus events passed from the pin front end to the protocol engine
// assumes both ends sit on the same clock
`timescale 1ns/1ns
interface smb_line_if;
   logic scl_rise;  // one-cycle pulse, filtered clock rose
   logic scl_fall;  // one-cycle pulse, filtered clock fell
   logic start_det; // start or repeated start seen
   logic stop_det;  // stop seen
   logic sda_lvl;   // filtered data level
   modport src (output scl_rise, scl_fall, start_det, stop_det, sda_lvl);
   modport dst (input scl_rise, scl_fall, start_det, stop_det, sda_lvl);
endinterface

// file: rtl/smb_line_sync.sv
// pin front end: synchronisers, filters and bus event detection
// assumes scl and sda arrive asynchronously from the board
`timescale 1ns/1ns
module smb_line_sync (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // raw pins
   input wire logic scl_in,
   input wire logic sda_in,
   // events out
   smb_line_if.src lif
);
   import smb_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // per line: three stages, level taken once stages two and three agree
   logic [1:0] pins;      // bit 0 scl, bit 1 sda
   logic [1:0] filt_reg;  // filtered levels
   logic [1:0] filt_next;
   assign pins = {sda_in, scl_in};

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_line
         logic [2:0] sh_reg; // stage 0 only feeds stage 1
         logic [2:0] sh_next;
         // shift and filter; a one-cycle glitch never reaches the level
         always_comb
         begin
            sh_next = {sh_reg[1:0], pins[g]};
            filt_next[g] = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : filt_reg[g];
         end
         // idle bus is high on both lines
         always_ff @(posedge clk)
         begin
            if (sys_rst)
            begin
               sh_reg <= 3'h7;
               filt_reg[g] <= 1'b1;
            end
            else
            begin
               sh_reg <= sh_next;
               filt_reg[g] <= filt_next[g];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // edge and condition pulses, registered
   logic rise_reg, fall_reg, start_reg, stop_reg;
   logic rise_next, fall_next, start_next, stop_next;

   // start/stop need scl high on both sides of the data change
   always_comb
   begin
      rise_next = ~filt_reg[0] & filt_next[0];
      fall_next = filt_reg[0] & ~filt_next[0];
      start_next = filt_reg[0] & filt_next[0] & filt_reg[1] & ~filt_next[1];
      stop_next = filt_reg[0] & filt_next[0] & ~filt_reg[1] & filt_next[1];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
         start_reg <= 1'b0;
         stop_reg <= 1'b0;
      end
      else
      begin
         rise_reg <= rise_next;
         fall_reg <= fall_next;
         start_reg <= start_next;
         stop_reg <= stop_next;
      end
   end

   assign lif.scl_rise = rise_reg;
   assign lif.scl_fall = fall_reg;
   assign lif.start_det = start_reg;
   assign lif.stop_det = stop_reg;
   assign lif.sda_lvl = filt_reg[1];
endmodule

// file: rtl/smb_target.sv
// smbus block read/write target with output gating registers
// assumes scl/sda pins from the board and straps static after power-up
`timescale 1ns/1ns
module smb_target (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // smbus pins, sda open-drain
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // address straps
   input wire smb_pkg::smb_strap_t addr_strap_high,
   input wire smb_pkg::smb_strap_t addr_strap_low,
   // output gating; muxed bits 5..0 are pairs 6..1
   output logic [5:0] fixed_out_en,
   output logic [5:0] muxed_out_en,
   output logic low_freq_out_en,
   output logic mux_freq_choice
);
   import smb_pkg::*;

   smb_line_if lif ();

   // filtered events from the pins
   smb_line_sync u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .lif(lif)
   );

   ////////////////////////////////////////////////////////////////////
   // address straps, caught once after reset release
   smb_byte_t own_addr_reg, own_addr_next;
   logic strap_done_reg, strap_done_next;
   logic [3:0] strap_idx;

   // a fourth strap code counts as high
   function automatic logic [3:0] lvl(input smb_strap_t s);
      lvl = (s > SMB_STRAP_HIGH) ? {2'h0, SMB_STRAP_HIGH} : {2'h0, s};
   endfunction

   always_comb
   begin
      strap_idx = 4'(lvl(addr_strap_high) * SMB_STRAP_MULT
                     + lvl(addr_strap_low));
      own_addr_next = own_addr_reg;
      strap_done_next = 1'b1;
      if (!strap_done_reg)
         own_addr_next = SMB_ADDR_TAB[strap_idx]; // [R11]
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         own_addr_reg <= SMB_ADDR_TAB[0];
         strap_done_reg <= 1'b0;
      end
      else
      begin
         own_addr_reg <= own_addr_next;
         strap_done_reg <= strap_done_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // protocol engine and register file
   localparam smb_byte_t WMASK [SMB_NUM_REGS] =
      '{SMB_MASK_FIXED, SMB_MASK_MUXED, SMB_MASK_SEL};
   localparam smb_byte_t RSTV [SMB_NUM_REGS] =
      '{SMB_RST_FIXED, SMB_RST_MUXED, SMB_RST_SEL};

   smb_state_t st_reg, st_next;
   smb_kind_t kind_reg, kind_next;
   logic [3:0] bit_reg, bit_next;      // bits done in this byte
   smb_byte_t rx_reg, rx_next;         // receive shifter
   smb_byte_t tx_reg, tx_next;         // transmit shifter
   smb_byte_t ptr_reg, ptr_next;       // register pointer
   smb_byte_t left_reg, left_next;     // write bytes still counted
   smb_byte_t cnt_reg, cnt_next;       // count returned on reads
   logic pend_reg, pend_next;          // read header owed after ack
   logic more_reg, more_next;          // host acked last read byte
   logic oe_reg, oe_next;              // pulling sda low
   smb_byte_t regs_reg [SMB_NUM_REGS];
   smb_byte_t regs_next [SMB_NUM_REGS];
   smb_byte_t rd_byte;

   // unimplemented offsets read as zero and drop writes
   always_comb
   begin
      rd_byte = 8'h00;
      for (int i = 0; i < SMB_NUM_REGS; i++)
         if (ptr_reg == 8'(i))
            rd_byte = regs_reg[i]; // [R17]
   end

   always_comb
   begin
      st_next = st_reg;
      kind_next = kind_reg;
      bit_next = bit_reg;
      rx_next = rx_reg;
      tx_next = tx_reg;
      ptr_next = ptr_reg;
      left_next = left_reg;
      cnt_next = cnt_reg;
      pend_next = pend_reg;
      more_next = more_reg;
      oe_next = oe_reg;
      regs_next = regs_reg;
      // a start wins over anything in flight, so a repeated start re-arms
      if (lif.start_det)
      begin
         st_next = SMB_ST_RX;
         kind_next = SMB_K_ADDR;
         bit_next = 4'h0;
         pend_next = 1'b0;
         oe_next = 1'b0;
      end
      else if (lif.stop_det)
      begin
         st_next = SMB_ST_IDLE;
         oe_next = 1'b0;
      end
      else
      begin
         case (st_reg)
            SMB_ST_RX:
            begin
               // sample on rise, decide on the fall after bit 8
               if (lif.scl_rise && bit_reg < SMB_BITS_BYTE)
               begin
                  rx_next = {rx_reg[6:0], lif.sda_lvl};
                  bit_next = bit_reg + 4'h1;
               end
               else if (lif.scl_fall && bit_reg == SMB_BITS_BYTE)
               begin
                  st_next = SMB_ST_ACK;
                  oe_next = 1'b1;
                  bit_next = 4'h0;
                  case (kind_reg)
                     SMB_K_ADDR:
                     begin
                        if (rx_reg[7:1] != own_addr_reg[7:1])
                        begin
                           st_next = SMB_ST_SKIP; // [R18]
                           oe_next = 1'b0;
                        end
                        else if (rx_reg[0])
                           pend_next = 1'b1; // [R7]
                        else
                           kind_next = SMB_K_OFF; // [R1]
                     end
                     SMB_K_OFF:
                     begin
                        ptr_next = rx_reg; // [R2]
                        kind_next = SMB_K_CNT;
                     end
                     SMB_K_CNT:
                     begin
                        left_next = rx_reg; // [R3]
                        cnt_next = rx_reg;
                        kind_next = SMB_K_DATA;
                     end
                     default:
                     begin
                        // bytes past the count are acked but not stored
                        if (left_reg != 8'h00)
                        begin
                           for (int i = 0; i < SMB_NUM_REGS; i++)
                              if (ptr_reg == 8'(i))
                                 regs_next[i] = rx_reg & WMASK[i]; // [R4]
                           left_next = left_reg - 8'h01;
                        end
                        ptr_next = ptr_reg + 8'h01; // [R4]
                     end
                  endcase
               end
            end
            SMB_ST_ACK:
            begin
               // release the ack on the fall that ends it
               if (lif.scl_fall)
               begin
                  oe_next = 1'b0;
                  st_next = SMB_ST_RX;
                  if (pend_next)
                  begin
                     tx_next = cnt_reg; // [R7]
                     oe_next = ~cnt_reg[7];
                     st_next = SMB_ST_TX;
                     pend_next = 1'b0;
                  end
               end
            end
            SMB_ST_TX:
            begin
               // next bit goes out on each fall, msb first
               if (lif.scl_fall)
               begin
                  if (bit_reg == SMB_BIT_LAST)
                  begin
                     oe_next = 1'b0;
                     st_next = SMB_ST_MACK;
                     bit_next = 4'h0;
                  end
                  else
                  begin
                     tx_next = {tx_reg[6:0], 1'b0};
                     oe_next = ~tx_reg[6];
                     bit_next = bit_reg + 4'h1;
                  end
               end
            end
            SMB_ST_MACK:
            begin
               if (lif.scl_rise)
                  more_next = ~lif.sda_lvl;
               else if (lif.scl_fall)
               begin
                  if (more_reg)
                  begin
                     tx_next = rd_byte; // [R8]
                     oe_next = ~rd_byte[7];
                     ptr_next = ptr_reg + 8'h01; // [R8]
                     st_next = SMB_ST_TX;
                  end
                  else
                     st_next = SMB_ST_SKIP; // host nack: wait for stop
               end
            end
            default:
               oe_next = 1'b0; // idle and skip keep sda released
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_reg <= SMB_ST_IDLE;
         kind_reg <= SMB_K_ADDR;
         bit_reg <= 4'h0;
         rx_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= 8'h00;
         left_reg <= 8'h00;
         cnt_reg <= SMB_RD_COUNT_RST;
         pend_reg <= 1'b0;
         more_reg <= 1'b0;
         oe_reg <= 1'b0;
         regs_reg <= RSTV; // [R12] [R14] [R15] [R16]
      end
      else
      begin
         st_reg <= st_next;
         kind_reg <= kind_next;
         bit_reg <= bit_next;
         rx_reg <= rx_next;
         tx_reg <= tx_next;
         ptr_reg <= ptr_next;
         left_reg <= left_next;
         cnt_reg <= cnt_next;
         pend_reg <= pend_next;
         more_reg <= more_next;
         oe_reg <= oe_next;
         regs_reg <= regs_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output stage; frequency choice only counts under the override
   logic sel_reg, sel_next;
   logic sda_lo_reg;

   always_comb
   begin
      sel_next = regs_reg[2][SMB_OVR_BIT] & regs_reg[2][SMB_CHOICE_BIT]; // [R16] [R17]
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sel_reg <= 1'b0;
         sda_lo_reg <= 1'b0;
      end
      else
      begin
         sel_reg <= sel_next;
         sda_lo_reg <= 1'b0; // open drain only ever pulls low
      end
   end

   assign sda_out = sda_lo_reg;
   assign sda_oe = oe_reg;
   assign fixed_out_en = regs_reg[0][SMB_FIXED_LSB +: 6]; // [R12]
   assign muxed_out_en = regs_reg[1][SMB_MUXED_LSB +: 6]; // [R14]
   assign low_freq_out_en = regs_reg[2][SMB_LOWF_BIT]; // [R15]
   assign mux_freq_choice = sel_reg;

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_byte_done(smb_kind_t k);
      st_reg == SMB_ST_RX && lif.scl_fall && bit_reg == SMB_BITS_BYTE
         && kind_reg == k && !lif.start_det && !lif.stop_det;
   endsequence

   property p_addr_ack;
      @(posedge clk) disable iff (sys_rst)
      s_byte_done(SMB_K_ADDR) ##0 (rx_reg[7:1] == own_addr_reg[7:1])
         |=> sda_oe && st_reg == SMB_ST_ACK;
   endproperty
   a_addr_ack: assert property (p_addr_ack) // [R1]
      else $error("matching address not acked");

   property p_off_load;
      @(posedge clk) disable iff (sys_rst)
      s_byte_done(SMB_K_OFF) |=> ptr_reg == $past(rx_reg) && sda_oe;
   endproperty
   a_off_load: assert property (p_off_load) // [R2]
      else $error("offset not loaded or not acked");

   property p_cnt_ack;
      @(posedge clk) disable iff (sys_rst)
      s_byte_done(SMB_K_CNT) |=> sda_oe && kind_reg == SMB_K_DATA;
   endproperty
   a_cnt_ack: assert property (p_cnt_ack) // [R3]
      else $error("count byte not acked");

   property p_data_store;
      @(posedge clk) disable iff (sys_rst)
      s_byte_done(SMB_K_DATA) ##0 (ptr_reg == SMB_REG_SEL && left_reg != 8'h00)
         |=> regs_reg[2] == ($past(rx_reg) & SMB_MASK_SEL) && sda_oe;
   endproperty
   a_data_store: assert property (p_data_store) // [R4]
      else $error("data byte not stored");

   property p_count_first;
      @(posedge clk) disable iff (sys_rst)
      st_reg == SMB_ST_ACK && pend_reg && lif.scl_fall
         && !lif.start_det && !lif.stop_det
         |=> st_reg == SMB_ST_TX && tx_reg == $past(cnt_reg)
            && sda_oe == ~tx_reg[7];
   endproperty
   a_count_first: assert property (p_count_first) // [R7]
      else $error("read did not open with count");

   property p_ascend;
      @(posedge clk) disable iff (sys_rst)
      st_reg == SMB_ST_MACK && more_reg && lif.scl_fall
         && !lif.start_det && !lif.stop_det
         |=> ptr_reg == $past(ptr_reg) + 8'h01 && st_reg == SMB_ST_TX;
   endproperty
   a_ascend: assert property (p_ascend) // [R8]
      else $error("read pointer did not advance");

   property p_strap;
      @(posedge clk) disable iff (sys_rst)
      $rose(strap_done_reg) |-> own_addr_reg == $past(SMB_ADDR_TAB[strap_idx]);
   endproperty
   a_strap: assert property (p_strap) // [R11]
      else $error("address not taken from straps");

   property p_skip_quiet;
      @(posedge clk) disable iff (sys_rst)
      st_reg == SMB_ST_SKIP |-> !sda_oe;
   endproperty
   a_skip_quiet: assert property (p_skip_quiet) // [R18]
      else $error("bus driven for foreign address");

   property p_no_ovr;
      @(posedge clk) disable iff (sys_rst)
      !regs_reg[2][SMB_OVR_BIT] ##1 !regs_reg[2][SMB_OVR_BIT] |-> !mux_freq_choice;
   endproperty
   a_no_ovr: assert property (p_no_ovr) // [R17]
      else $error("25 MHz chosen without override");
endmodule

// file: dv/smb_host_model.sv
// smbus host model: drives scl, shares the open-drain sda, reports results
// assumes a pull-up on sda and a target that pulls low while its oe is high
`timescale 1ns/1ns
module smb_host_model (
   // clock
   input wire logic clk,
   // target pull-down enable
   input wire logic dev_oe,
   // bus wires as seen by the target
   output logic scl,
   output logic sda,
   // result: ack bit (0 = ack) or a received byte
   output logic res_stb,
   output smb_pkg::smb_byte_t res_val
);
   import smb_pkg::*;
   logic host_lvl; // 1 = released, the pull-up wins
   ////////////////////////////////////////////////////////////////////////
   // wired-and: a released line floats to the pull-up level
   assign sda = host_lvl & ~dev_oe;
   initial
   begin
      scl = 1'b1;
      host_lvl = 1'b1;
      res_stb = 1'b0;
      res_val = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////
   // all pin changes land just after a clock edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one bit: 16 clk low, 16 clk high; data moves mid-low for hold margin
   task automatic bitx(input logic b, output logic s);
      scl = 1'b0;
      tick(8);
      host_lvl = b;
      tick(8);
      scl = 1'b1;
      tick(8);
      s = sda;
      tick(8);
   endtask
   // one-cycle result pulse, taken while scl is still high
   task automatic post(input smb_byte_t v);
      res_val = v;
      res_stb = 1'b1;
      tick(1);
      res_stb = 1'b0;
   endtask
   // byte out msb first, then report the ack bit
   task automatic send(input smb_byte_t b);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitx(b[i], s);
      bitx(1'b1, s);
      post({7'h00, s});
   endtask
   // byte in; ack unless last, nack on the last one
   task automatic recv(input logic last);
      smb_byte_t v;
      logic s;
      for (int i = 7; i >= 0; i--)
         bitx(1'b1, v[i]);
      bitx(last, s);
      post(v);
   endtask
   // start or repeated start: sda falls while scl is high
   task automatic start;
      scl = 1'b0;
      tick(8);
      host_lvl = 1'b1;
      tick(8);
      scl = 1'b1;
      tick(16);
      host_lvl = 1'b0;
      tick(16);
   endtask
   // stop: sda rises while scl is high, bus left idle
   task automatic stop;
      scl = 1'b0;
      tick(8);
      host_lvl = 1'b0;
      tick(8);
      scl = 1'b1;
      tick(16);
      host_lvl = 1'b1;
      tick(16);
   endtask
endmodule

// file: dv/smbus_block_output_control_test.sv
// bench for the smbus target: straps, block writes, block reads
// assumes the host model drives the pins and pulses each bus result
`timescale 1ns/1ns
module smbus_block_output_control_test;
   import smb_pkg::*;
   // clock, reset, straps
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   smb_strap_t strap_hi = 2'h0;
   smb_strap_t strap_lo = 2'h0;
   // pins and gates
   logic scl, sda, sda_out, sda_oe, low_freq_out_en, mux_freq_choice;
   logic [5:0] fixed_out_en, muxed_out_en;
   logic res_stb;
   smb_byte_t res_val;
   // bookkeeping
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int seed = 32'h23d4bc83;
   smb_byte_t exp_q[$]; // expected bus results, oldest first
   smb_byte_t dq[$]; // data bytes of the next write
   smb_byte_t mdl[3]; // expected register contents
   smb_byte_t cnt_mdl; // expected count byte of a read
   smb_byte_t own; // strapped address, write form
   // addresses in strap order, high level times three plus low level
   localparam smb_byte_t adr_tab[9] = '{8'hd2, 8'hd4, 8'hd6, 8'hb2,
      8'hb4, 8'hb6, 8'hba, 8'hbc, 8'hbe};
   ////////////////////////////////////////////////////////////////////////
   always #5 clk = ~clk;
   smb_target u_smb_target (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_strap_high(strap_hi), .addr_strap_low(strap_lo),
      .fixed_out_en(fixed_out_en), .muxed_out_en(muxed_out_en),
      .low_freq_out_en(low_freq_out_en), .mux_freq_choice(mux_freq_choice));
   smb_host_model u_smb_host_model (.clk(clk), .dev_oe(sda_oe), .scl(scl),
      .sda(sda), .res_stb(res_stb), .res_val(res_val));
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input smb_byte_t got, input smb_byte_t exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // two kinds of result: bytes on the bus and output gates
   task automatic cmp_res(input smb_byte_t got, input smb_byte_t exp);
      check(got, exp);
   endtask
   task automatic cmp_out(input smb_byte_t got, input smb_byte_t exp);
      check(got, exp);
   endtask
   // straps are set with reset held and stay put afterwards
   task automatic do_reset(input smb_strap_t hi, input smb_strap_t lo);
      @(posedge clk);
      #1;
      sys_rst = 1'b1;
      strap_hi = hi;
      strap_lo = lo;
      repeat (8) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      repeat (8) @(posedge clk);
      own = adr_tab[int'(hi) * 3 + int'(lo)];
      mdl = '{8'h3f, 8'h7e, 8'h04};
      cnt_mdl = 8'h03;
   endtask
   // note the expected ack, then send the byte
   task automatic wb(input smb_byte_t b, input logic ack);
      exp_q.push_back(ack ? 8'h00 : 8'h01);
      u_smb_host_model.send(b);
   endtask
   task automatic rb(input smb_byte_t exp, input logic last);
      exp_q.push_back(exp);
      u_smb_host_model.recv(last);
   endtask
   // gates after a short settle; the frequency choice lags one clock
   task automatic chk;
      repeat (4) @(posedge clk);
      cmp_out({2'h0, fixed_out_en}, {2'h0, mdl[0][5:0]});
      cmp_out({2'h0, muxed_out_en}, {2'h0, mdl[1][6:1]});
      cmp_out({7'h0, low_freq_out_en}, {7'h0, mdl[2][2]});
      cmp_out({7'h0, mux_freq_choice}, {7'h0, mdl[2][7] & mdl[2][6]});
   endtask
   // block write of dq; bytes past the count are acked but dropped
   task automatic wr(input smb_byte_t n, input smb_byte_t x);
      smb_byte_t msk[3];
      msk = '{SMB_MASK_FIXED, SMB_MASK_MUXED, SMB_MASK_SEL};
      u_smb_host_model.start();
      wb(own, 1'b1);
      wb(n, 1'b1);
      wb(x, 1'b1);
      foreach (dq[i])
      begin
         wb(dq[i], 1'b1);
         if (i < x && n + i < 3)
            mdl[n + i] = dq[i] & msk[n + i];
      end
      u_smb_host_model.stop();
      cnt_mdl = x;
      chk();
   endtask
   // block read of nb bytes from n; offsets past the table read zero
   task automatic rd(input smb_byte_t n, input int nb);
      u_smb_host_model.start();
      wb(own, 1'b1);
      wb(n, 1'b1);
      u_smb_host_model.start();
      wb(own | 8'h01, 1'b1);
      rb(cnt_mdl, 1'b0);
      for (int i = 0; i < nb; i++)
         rb((n + i < 3) ? mdl[n + i] : 8'h00, i == nb - 1);
      u_smb_host_model.stop();
   endtask
   function automatic smb_byte_t rnd(input smb_byte_t msk);
      return smb_byte_t'($random(seed)) & msk;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // results are compared in arrival order against the notes
   always @(posedge clk)
      if (res_stb === 1'b1)
         cmp_res(res_val, exp_q.pop_front());
   // hang guard, well above the expected run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         errors++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      // every strap pair: own address acked, a foreign one ignored
      for (int h = 0; h < 3; h++)
         for (int l = 0; l < 3; l++)
         begin
            do_reset(smb_strap_t'(h), smb_strap_t'(l));
            chk();
            u_smb_host_model.start();
            wb(own, 1'b1);
            u_smb_host_model.stop();
            u_smb_host_model.start();
            wb(adr_tab[(h * 3 + l + 1) % 9], 1'b0);
            wb(8'h00, 1'b0);
            u_smb_host_model.stop();
         end
      // full writes then read-back; first pass sets choice without override
      for (int i = 0; i < 4; i++)
      begin
         dq = '{rnd(8'h3f), rnd(8'h7e), (i == 0) ? 8'h80 : rnd(8'hc4)};
         wr(8'h00, 8'h03);
         rd(8'h00, 3);
      end
      // count of one with a surplus byte; reserved bits written as ones
      dq = '{8'hff, 8'h00};
      wr(8'h00, 8'h01);
      rd(8'h01, 3);
      finish_test();
   end
endmodule
